/* fieb_pkg.sv */
package fieb_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] SLEEP_EXIT_OFS = 8'h19;
    localparam logic [7:0] SLEEP_ENTRY_OFS = 8'h1A;
    localparam logic [7:0] CONTROL_OFS = 8'h1B;
    localparam logic [7:0] SELFTEST_OFS = 8'h1C;
    localparam logic [7:0] VENDOR_OFS = 8'h1D;

    // ==========================================================
    // Writable bit masks; reserved bits hold zero and read as zero.
    localparam logic [7:0] CHANNEL_MASK = 8'h3F;
    localparam logic [7:0] CONTROL_MASK = 8'h17;
    localparam logic [7:0] SELFTEST_MASK = 8'h0B;
    localparam logic [7:0] VENDOR_MASK = 8'h8F;

    // ==========================================================
    // Field positions
    localparam int CTL_REG_CHECK_BIT = 4;
    localparam int CTL_OVER_TEMP_BIT = 2;
    localparam int CTL_LINK_PIN_BIT = 1;
    localparam int CTL_PACKET_CODE_BIT = 0;
    localparam int TST_OTP_CORRECT_BIT = 3;
    localparam int TST_SELFTEST_DONE_BIT = 1;
    localparam int TST_SELFTEST_FAULT_BIT = 0;
    localparam int VND_WRITE_READBACK_BIT = 7;
    localparam int VND_VOTING_FAIL_BIT = 3;
    localparam int VND_CONVERTER_FAIL_BIT = 2;
    localparam int VND_CONSEC_WRITE_BIT = 1;
    localparam int VND_STATE_FAIL_BIT = 0;

    // ==========================================================
    // Values after reset, before the configuration memory is loaded
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] sleepExit;
        logic [7:0] sleepEntry;
        logic [7:0] control;
        logic [7:0] selftest;
        logic [7:0] vendor;
    } fieb_bank_t;

    localparam fieb_bank_t BANK_RESET = '{
        sleepExit: 8'h00,
        sleepEntry: 8'h00,
        control: 8'h00,
        selftest: 8'h00,
        vendor: 8'h00
    };

    typedef enum logic [1:0] {
        FIEB_LOADING = 2'b01,
        FIEB_READY = 2'b10
    } fieb_state_t;

endpackage

/* fieb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module fieb_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration memory load
    input wire logic otpLoadValid,
    input wire fieb_pkg::fieb_bank_t otpImage,
    // Protection group
    input wire logic enableGroupLocked,
    // Register port from the serial front end
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic regWrRefused,
    // Latched fault flags and direct self-test failure
    input wire fieb_pkg::fieb_bank_t faultFlags,
    input wire logic logicSelftestFail,
    // Enables and interrupt status
    output fieb_pkg::fieb_bank_t irqEnables,
    output logic [4:0] irqPending,
    output logic bankReady,
    output logic faultIrqN
);

    // ==========================================================
    // Reset release
    logic [1:0] rstSync;
    logic rstN;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync <= fieb_pkg::RESET_SYNC_INIT;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    assign rstN = rstSync[1];

    // ==========================================================
    // Load sequencing
    fieb_pkg::fieb_state_t state;
    fieb_pkg::fieb_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            fieb_pkg::FIEB_LOADING: begin
                if (otpLoadValid) begin
                    next_state = fieb_pkg::FIEB_READY;
                end
            end
            fieb_pkg::FIEB_READY: begin
                next_state = fieb_pkg::FIEB_READY;
            end
            default: begin
                next_state = fieb_pkg::FIEB_LOADING;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state <= fieb_pkg::FIEB_LOADING;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Enable registers
    // Host writes are refused until the load so that a write cannot be overwritten
    // by the power-on image a few cycles later.
    fieb_pkg::fieb_bank_t bank;
    fieb_pkg::fieb_bank_t next_bank;
    logic hostWrite;
    logic next_regWrRefused;

    assign hostWrite = regWrEn && (state == fieb_pkg::FIEB_READY) && !enableGroupLocked;

    always_comb begin
        next_bank = bank;
        next_regWrRefused = 1'b0;
        if (state == fieb_pkg::FIEB_LOADING) begin
            if (otpLoadValid) begin
                next_bank.sleepExit = otpImage.sleepExit & fieb_pkg::CHANNEL_MASK;
                next_bank.sleepEntry = otpImage.sleepEntry & fieb_pkg::CHANNEL_MASK;
                next_bank.control = otpImage.control & fieb_pkg::CONTROL_MASK;
                next_bank.selftest = otpImage.selftest & fieb_pkg::SELFTEST_MASK;
                next_bank.vendor = otpImage.vendor & fieb_pkg::VENDOR_MASK;
            end
            next_regWrRefused = regWrEn;
        end else if (hostWrite) begin
            case (regAddr)
                fieb_pkg::SLEEP_EXIT_OFS: begin
                    next_bank.sleepExit = regWrData & fieb_pkg::CHANNEL_MASK;
                end
                fieb_pkg::SLEEP_ENTRY_OFS: begin
                    next_bank.sleepEntry = regWrData & fieb_pkg::CHANNEL_MASK;
                end
                fieb_pkg::CONTROL_OFS: begin
                    next_bank.control = regWrData & fieb_pkg::CONTROL_MASK;
                end
                fieb_pkg::SELFTEST_OFS: begin
                    next_bank.selftest = regWrData & fieb_pkg::SELFTEST_MASK;
                end
                fieb_pkg::VENDOR_OFS: begin
                    next_bank.vendor = regWrData & fieb_pkg::VENDOR_MASK;
                end
                default: begin
                    next_bank = bank;
                end
            endcase
        end else if (regWrEn) begin
            next_regWrRefused = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            bank <= fieb_pkg::BANK_RESET;
            regWrRefused <= 1'b0;
        end else begin
            bank <= next_bank;
            regWrRefused <= next_regWrRefused;
        end
    end

    // ==========================================================
    // Read path
    logic [7:0] next_regRdData;
    logic next_regRdValid;

    always_comb begin
        next_regRdValid = regRdEn;
        next_regRdData = fieb_pkg::ENABLE_RESET;
        if (regRdEn) begin
            case (regAddr)
                fieb_pkg::SLEEP_EXIT_OFS: begin
                    next_regRdData = bank.sleepExit;
                end
                fieb_pkg::SLEEP_ENTRY_OFS: begin
                    next_regRdData = bank.sleepEntry;
                end
                fieb_pkg::CONTROL_OFS: begin
                    next_regRdData = bank.control;
                end
                fieb_pkg::SELFTEST_OFS: begin
                    next_regRdData = bank.selftest;
                end
                fieb_pkg::VENDOR_OFS: begin
                    next_regRdData = bank.vendor;
                end
                default: begin
                    next_regRdData = fieb_pkg::ENABLE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= fieb_pkg::ENABLE_RESET;
            regRdValid <= 1'b0;
        end else begin
            regRdData <= next_regRdData;
            regRdValid <= next_regRdValid;
        end
    end

    // ==========================================================
    // Interrupt gating
    // Flags are only read here, never written, so an enable change cannot
    // disturb them; clearing stays with the flag registers.
    logic seqExitHit;
    logic seqEntryHit;
    logic controlHit;
    logic selftestHit;
    logic vendorHit;
    logic [4:0] next_irqPending;
    logic next_faultIrqN;

    always_comb begin
        seqExitHit = |(faultFlags.sleepExit & bank.sleepExit & fieb_pkg::CHANNEL_MASK);
        seqEntryHit = |(faultFlags.sleepEntry & bank.sleepEntry & fieb_pkg::CHANNEL_MASK);
        controlHit = 1'b0;
        controlHit = controlHit
            | (faultFlags.control[fieb_pkg::CTL_REG_CHECK_BIT]
               & bank.control[fieb_pkg::CTL_REG_CHECK_BIT]);
        controlHit = controlHit
            | (faultFlags.control[fieb_pkg::CTL_OVER_TEMP_BIT]
               & bank.control[fieb_pkg::CTL_OVER_TEMP_BIT]);
        controlHit = controlHit
            | (faultFlags.control[fieb_pkg::CTL_LINK_PIN_BIT]
               & bank.control[fieb_pkg::CTL_LINK_PIN_BIT]);
        controlHit = controlHit
            | (faultFlags.control[fieb_pkg::CTL_PACKET_CODE_BIT]
               & bank.control[fieb_pkg::CTL_PACKET_CODE_BIT]);
        selftestHit = 1'b0;
        selftestHit = selftestHit
            | (faultFlags.selftest[fieb_pkg::TST_OTP_CORRECT_BIT]
               & bank.selftest[fieb_pkg::TST_OTP_CORRECT_BIT]);
        selftestHit = selftestHit
            | (faultFlags.selftest[fieb_pkg::TST_SELFTEST_DONE_BIT]
               & bank.selftest[fieb_pkg::TST_SELFTEST_DONE_BIT]);
        selftestHit = selftestHit
            | (faultFlags.selftest[fieb_pkg::TST_SELFTEST_FAULT_BIT]
               & bank.selftest[fieb_pkg::TST_SELFTEST_FAULT_BIT]);
        vendorHit = 1'b0;
        vendorHit = vendorHit
            | (faultFlags.vendor[fieb_pkg::VND_WRITE_READBACK_BIT]
               & bank.vendor[fieb_pkg::VND_WRITE_READBACK_BIT]);
        vendorHit = vendorHit
            | (faultFlags.vendor[fieb_pkg::VND_VOTING_FAIL_BIT]
               & bank.vendor[fieb_pkg::VND_VOTING_FAIL_BIT]);
        vendorHit = vendorHit
            | (faultFlags.vendor[fieb_pkg::VND_CONVERTER_FAIL_BIT]
               & bank.vendor[fieb_pkg::VND_CONVERTER_FAIL_BIT])
            | (faultFlags.vendor[fieb_pkg::VND_CONSEC_WRITE_BIT]
               & bank.vendor[fieb_pkg::VND_CONSEC_WRITE_BIT])
            | (faultFlags.vendor[fieb_pkg::VND_STATE_FAIL_BIT]
               & bank.vendor[fieb_pkg::VND_STATE_FAIL_BIT]);
        next_irqPending = {vendorHit, selftestHit, controlHit, seqEntryHit, seqExitHit};
        next_faultIrqN = !((|next_irqPending) || logicSelftestFail);
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            irqPending <= 5'h00;
            faultIrqN <= 1'b1;
        end else begin
            irqPending <= next_irqPending;
            faultIrqN <= next_faultIrqN;
        end
    end

    // ==========================================================
    // Status outputs
    fieb_pkg::fieb_bank_t next_irqEnables;
    logic next_bankReady;

    always_comb begin
        next_irqEnables = next_bank;
        next_bankReady = (next_state == fieb_pkg::FIEB_READY);
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            irqEnables <= fieb_pkg::BANK_RESET;
            bankReady <= 1'b0;
        end else begin
            irqEnables <= next_irqEnables;
            bankReady <= next_bankReady;
        end
    end

endmodule // fieb_top

`default_nettype wire

/* fieb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fieb_host_model (
    // Clock
    input wire logic ref_clk,
    // Register port toward the bank
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    // Answers from the bank
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic regWrRefused
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // Flags untouched here; they clear only by write-one-to-clear elsewhere.
    // Own readback: every write is read back by the host itself.
    task automatic wr_check(input logic [7:0] a, input logic [7:0] d, output logic [7:0] back,
                            output logic refused);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
        regRdEn = 1'b1;
        refused = regWrRefused;
        @(posedge ref_clk);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        // Released lines show the inverse of the last value, so a stale value is never read as fresh.
        back = regRdValid ? regRdData : 8'hEE;
    endtask
endmodule // fieb_host_model
`default_nettype wire

/* fieb_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fieb_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Inputs of the bank
    input wire logic otpLoadValid,
    input wire fieb_pkg::fieb_bank_t otpImage,
    input wire logic enableGroupLocked,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire fieb_pkg::fieb_bank_t faultFlags,
    input wire logic logicSelftestFail,
    // Outputs of the bank
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic regWrRefused,
    input wire fieb_pkg::fieb_bank_t irqEnables,
    input wire logic [4:0] irqPending,
    input wire logic bankReady,
    input wire logic faultIrqN
);
    logic [39:0] mask;
    logic [39:0] hit;
    assign mask = {fieb_pkg::CHANNEL_MASK, fieb_pkg::CHANNEL_MASK, fieb_pkg::CONTROL_MASK,
                   fieb_pkg::SELFTEST_MASK, fieb_pkg::VENDOR_MASK};
    assign hit = faultFlags & irqEnables;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence load_taken;
        otpLoadValid && !bankReady;
    endsequence
    sequence bank_loaded;
        bankReady && irqEnables == ($past(otpImage) & mask);
    endsequence
    sequence reserved_clear;
        (irqEnables & ~mask) == 40'h0;
    endsequence
    sequence ctl_write;
        regWrEn && !enableGroupLocked && bankReady && regAddr == fieb_pkg::CONTROL_OFS;
    endsequence
    sequence ctl_landed;
        irqEnables.control == ($past(regWrData) & fieb_pkg::CONTROL_MASK);
    endsequence
    sequence locked_write;
        regWrEn && enableGroupLocked && bankReady;
    endsequence
    sequence write_dropped;
        regWrRefused && $stable(irqEnables);
    endsequence
    sequence exit_read;
        regRdEn && bankReady && regAddr == fieb_pkg::SLEEP_EXIT_OFS;
    endsequence
    sequence exit_answer;
        regRdData == $past(irqEnables.sleepExit);
    endsequence
    sequence pending_match;
        irqPending == {|$past(hit[7:0]), |$past(hit[15:8]), |$past(hit[23:16]),
            |$past(hit[31:24]), |$past(hit[39:32])};
    endsequence
    a_otp_load: assert property (load_taken |=> bank_loaded)
        else $error("bank not loaded from image");
    a_reserved_zero: assert property (bankReady |-> reserved_clear)
        else $error("reserved enable bit set");
    a_control_write: assert property (ctl_write |=> ctl_landed)
        else $error("control write did not land");
    a_locked_hold: assert property (locked_write |=> write_dropped)
        else $error("locked write changed bank");
    a_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    a_exit_read: assert property (exit_read |=> exit_answer)
        else $error("exit enable read wrong");
    a_selftest_bypass: assert property (logicSelftestFail |=> !faultIrqN)
        else $error("self-test failure not on pin");
    a_pin_follows: assert property (!$past(logicSelftestFail) |-> faultIrqN == !(|irqPending))
        else $error("pin disagrees with pending");
    a_pending_cause: assert property (1'b1 |=> pending_match)
        else $error("pending groups wrong");
endmodule // fieb_checker
bind fieb_top fieb_checker chk_u (.ref_clk(ref_clk), .nrst(nrst), .otpLoadValid(otpLoadValid),
    .otpImage(otpImage), .enableGroupLocked(enableGroupLocked), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .faultFlags(faultFlags),
    .logicSelftestFail(logicSelftestFail), .regRdData(regRdData), .regRdValid(regRdValid),
    .regWrRefused(regWrRefused), .irqEnables(irqEnables), .irqPending(irqPending),
    .bankReady(bankReady), .faultIrqN(faultIrqN));
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, nrst, otpLoadValid, enableGroupLocked, logicSelftestFail;
    logic regWrEn, regRdEn, regRdValid, regWrRefused, bankReady, faultIrqN, bad;
    logic [7:0] regAddr, regWrData, regRdData, back;
    logic [4:0] irqPending;
    fieb_pkg::fieb_bank_t otpImage, faultFlags, irqEnables, en;
    int fail_count, num_checks, cycles, k;
    fieb_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .otpLoadValid(otpLoadValid),
        .otpImage(otpImage), .enableGroupLocked(enableGroupLocked), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .regWrRefused(regWrRefused), .faultFlags(faultFlags),
        .logicSelftestFail(logicSelftestFail), .irqEnables(irqEnables),
        .irqPending(irqPending), .bankReady(bankReady), .faultIrqN(faultIrqN));
    fieb_host_model host_u (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .regWrRefused(regWrRefused));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [39:0] masked(input logic [39:0] b);
        return b & {fieb_pkg::CHANNEL_MASK, fieb_pkg::CHANNEL_MASK, fieb_pkg::CONTROL_MASK,
                    fieb_pkg::SELFTEST_MASK, fieb_pkg::VENDOR_MASK};
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Budget is under two hundred cycles; the ceiling leaves a wide margin.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic reg_set(input int idx, input logic [7:0] d, input logic refused);
        host_u.wr_check(fieb_pkg::SLEEP_EXIT_OFS + 8'(idx), d, back, bad);
        if (!refused) en[8*(4-idx) +: 8] = d;
        en = masked(en);
        check(bad, refused);
        check(back, en[8*(4-idx) +: 8]);
        check(irqEnables, en);
    endtask
    task automatic irq_check(input logic [39:0] f);
        faultFlags = f;
        repeat (2) @(posedge ref_clk);
        #1;
        check(irqPending, {|(f[7:0] & en[7:0]), |(f[15:8] & en[15:8]),
            |(f[23:16] & en[23:16]), |(f[31:24] & en[31:24]), |(f[39:32] & en[39:32])});
        check(faultIrqN, !((|(f & en)) || logicSelftestFail));
    endtask
    initial begin
        {nrst, otpLoadValid, enableGroupLocked, logicSelftestFail} = 4'h0;
        {otpImage, faultFlags, en} = 120'h0;
        {fail_count, num_checks, cycles} = 96'h0;
        void'($urandom(32'h5dc33c84));
        repeat (8) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        check({bankReady, faultIrqN, irqEnables}, 42'h1_00_0000_0000);
        repeat (3) @(posedge ref_clk);
        reg_set(2, 8'hFF, 1'b1);
        otpImage = 40'({$urandom, $urandom});
        otpLoadValid = 1'b1;
        @(posedge ref_clk);
        #1;
        otpImage = ~otpImage;
        en = masked(~otpImage);
        check({bankReady, irqEnables}, {1'b1, en});
        @(posedge ref_clk);
        #1;
        otpLoadValid = 1'b0;
        check(irqEnables, en);
        for (k = 0; k < 25; k++) begin
            reg_set(k % 5, (k < 5) ? 8'hFF : 8'($urandom), 1'b0);
            irq_check((k % 4 == 0) ? 40'h0 : 40'({$urandom, $urandom}));
        end
        for (k = 0; k < 2; k++) begin
            host_u.wr_check(k ? 8'h1E : 8'h18, 8'hA5, back, bad);
            check({bad, back, irqEnables}, {9'h0, en});
        end
        enableGroupLocked = 1'b1;
        reg_set(4, ~en[7:0], 1'b1);
        enableGroupLocked = 1'b0;
        reg_set(2, 8'h04, 1'b0);
        irq_check(40'h00_00_04_00_00);
        reg_set(2, 8'h00, 1'b0);
        irq_check(40'h00_00_04_00_00);
        reg_set(3, 8'h00, 1'b0);
        logicSelftestFail = 1'b1;
        irq_check(40'h00_00_00_01_00);
        check(faultIrqN, 1'b0);
        logicSelftestFail = 1'b0;
        reg_set(3, 8'h01, 1'b0);
        irq_check(40'h00_00_00_01_00);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
